/* File: hdl/iopa_adder.sv */
// Combinational adder: add, or complement-and-add-one for subtract
`timescale 1ns/10ps
`default_nettype none
module iopa_adder
   import iopa_pkg::*;
(
   input wire logic [DATA_W-1:0] a,
   input wire logic [DATA_W-1:0] b,
   input wire logic sub,
   output logic [DATA_W-1:0] sum,
   output logic carry
);
   logic [DATA_W-1:0] b_in;
   logic [DATA_W:0] s1;
   logic [DATA_W:0] s2;
   // Two additions; a carry out of either counts, as subtract demands
   always_comb begin
      b_in = sub ? ~b : b;
      s1 = {1'b0, a} + {1'b0, b_in};
      s2 = {1'b0, s1[DATA_W-1:0]} + {{DATA_W{1'b0}}, sub};
      sum = s2[DATA_W-1:0];
      carry = s1[DATA_W] | s2[DATA_W];
   end
endmodule
`default_nettype wire

/* File: hdl/iopa_datapath.sv */
// Accumulator datapath top: sequencer, accumulator, carry, addend, pointers
// What this block does
// - Small-designator subtract: addend at issue, adder period 1, result period 2.
// - Load constant puts next parcel in accumulator, clears carry; two parcels.
// - Constant instructions read the next parcel; period 1 stalls until present.
// - AND constant ANDs accumulator with constant at its input, clears carry.
// - Add constant: addend period 1, adder period 2, result period 3; toggle carry.
// - Subtract constant adds complement plus one; either carry toggles carry.
// - Load register: designator to read pointer, register to accumulator, clear carry.
// - AND register ANDs at accumulator input in period 1, clears carry.
// - Add register: addend period 1, adder period 2, result period 3.
// - Subtract register complements operand, adds plus one, toggles carry.
// - Store register loads both pointers at issue, writes accumulator period 1.
// - Register-writing instructions wait while writeback pointer is still held.
// - Store waits for accumulator data, holding both pointers meanwhile.
// - Add-and-store: sum in accumulator period 3, written back period 4.
// - Read-modify-write drops read pointer period 1, reloads from writeback period 3.
// - Add-and-store period-1 transfer stalls until accumulator data available.
// - Increment clears carry, forces plus one, adds register, sets carry on carry-out.
// - Decrement forces all ones, adds register, sets carry on carry-out, writes back period 4.
// - Memory load uses operand register as address, fetched word into accumulator.
// - Small designators are 9-bit unsigned, zero-extended to 16 bits.
// - Memory request re-sent each period until acceptance; memory must accept.
`timescale 1ns/10ps
`default_nettype none
module iopa_datapath
   import iopa_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire iopa_issue_s ISSUE,
   input wire logic [DATA_W-1:0] PARCEL_DATA,
   input wire logic PARCEL_VALID,
   input wire logic [DATA_W-1:0] OPREG_RDATA,
   input wire logic ACC_AVAIL,
   input wire logic MEM_ACCEPT,
   input wire logic MEM_RVALID,
   input wire logic [DATA_W-1:0] MEM_RDATA,
   output logic ISSUE_READY,
   output logic PARCEL_TAKE,
   output logic [PTR_W-1:0] OPERAND_READ_POINTER,
   output logic OPERAND_READ_VALID,
   output logic [PTR_W-1:0] WRITEBACK_POINTER,
   output iopa_opwr_s OPREG_WR,
   output logic [DATA_W-1:0] MEMORY_ADDRESS_LATCH,
   output logic MEM_REQ,
   output logic [DATA_W-1:0] ACC,
   output logic CARRY
);
   iopa_state_e state_ff, nxt_state;
   iopa_op_e op_ff, nxt_op;
   logic [DATA_W-1:0] acc_ff, nxt_acc;
   logic carry_ff, nxt_carry;
   logic [DATA_W-1:0] addend_ff, nxt_addend;
   logic sub_ff, nxt_sub;
   logic [PTR_W-1:0] rp_ff, nxt_rp;
   logic rp_vld_ff, nxt_rp_vld;
   iopa_opwr_s wr_ff, nxt_wr;
   logic [DATA_W-1:0] ma_ff, nxt_ma;
   logic mreq_ff, nxt_mreq;
   logic take_ff, nxt_take;
   logic ready_ff; // Registered from the next state, so from the first edge after reset ready matches the current state with no lag
   logic [DATA_W-1:0] add_sum;
   logic add_carry;
   logic wb_busy;
   logic [PTR_W-1:0] wb_ptr;
   logic wb_load;
   logic wb_release;
   logic issue_ok;
   logic [DATA_W-1:0] desig_ext;

   // True for operations that write an operand register
   function automatic logic writes_reg(input iopa_op_e op);
      writes_reg = (op == OP_ST_R) || (op == OP_ADDST_R) || (op == OP_INC_R) ||
         (op == OP_DEC_R);
   endfunction

   iopa_adder u_adder (
      .a(acc_ff),
      .b(addend_ff),
      .sub(sub_ff),
      .sum(add_sum),
      .carry(add_carry)
   );

   iopa_wb_track u_wb (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .load(wb_load),
      .load_ptr(ISSUE.desig),
      .release_ptr(wb_release),
      .busy(wb_busy),
      .ptr(wb_ptr)
   );

   // Issue gate: register writers wait while a writeback pointer is still held
   always_comb begin
      desig_ext = {{(DATA_W-DESIG_W){1'b0}}, ISSUE.desig};
      issue_ok = ISSUE.valid && (state_ff == S_IDLE) &&
         !(writes_reg(ISSUE.op) && wb_busy);
      wb_load = issue_ok && writes_reg(ISSUE.op);
   end

   // Sequencer and datapath next values
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_acc = acc_ff;
      nxt_carry = carry_ff;
      nxt_addend = addend_ff;
      nxt_sub = sub_ff;
      nxt_rp = rp_ff;
      nxt_rp_vld = rp_vld_ff;
      nxt_wr = '0;
      nxt_wr.ptr = wr_ff.ptr;
      nxt_wr.data = wr_ff.data;
      nxt_ma = ma_ff;
      nxt_mreq = 1'b0;
      nxt_take = 1'b0;
      wb_release = 1'b0;
      case (state_ff)
         S_IDLE: begin
            if (issue_ok) begin
               nxt_op = ISSUE.op;
               case (ISSUE.op)
                  OP_ADD_D, OP_SUB_D: begin
                     nxt_addend = desig_ext;
                     nxt_sub = (ISSUE.op == OP_SUB_D);
                     nxt_state = S_ADD;
                  end
                  OP_LD_K, OP_AND_K, OP_ADD_K, OP_SUB_K: begin
                     nxt_state = S_CP1;
                  end
                  OP_LD_R, OP_AND_R, OP_ADD_R, OP_SUB_R, OP_ST_R, OP_ADDST_R,
                  OP_INC_R, OP_DEC_R, OP_LD_M: begin
                     nxt_rp = ISSUE.desig;
                     nxt_rp_vld = 1'b1;
                     nxt_state = S_CP1;
                  end
                  default: begin
                     nxt_state = S_IDLE;
                  end
               endcase
            end
         end
         S_CP1: begin
            nxt_sub = (op_ff == OP_SUB_K) || (op_ff == OP_SUB_R);
            case (op_ff)
               OP_LD_K, OP_AND_K, OP_ADD_K, OP_SUB_K: begin
                  // Constant parcel may lag the issue; hold period 1 until present
                  if (PARCEL_VALID) begin
                     nxt_take = 1'b1;
                     if (op_ff == OP_LD_K) begin
                        nxt_acc = PARCEL_DATA;
                        nxt_carry = 1'b0;
                        nxt_state = S_IDLE;
                     end else if (op_ff == OP_AND_K) begin
                        nxt_acc = acc_ff & PARCEL_DATA;
                        nxt_carry = 1'b0;
                        nxt_state = S_IDLE;
                     end else begin
                        nxt_addend = PARCEL_DATA;
                        nxt_state = S_ADD;
                     end
                  end
               end
               OP_LD_R, OP_AND_R: begin
                  nxt_acc = (op_ff == OP_LD_R) ? OPREG_RDATA
                     : (acc_ff & OPREG_RDATA);
                  nxt_carry = 1'b0;
                  nxt_rp_vld = 1'b0;
                  nxt_state = S_IDLE;
               end
               OP_ADD_R, OP_SUB_R: begin
                  nxt_addend = OPREG_RDATA;
                  nxt_rp_vld = 1'b0;
                  nxt_state = S_ADD;
               end
               OP_ST_R: begin
                  // Pointers stay put while the accumulator is still pending
                  if (ACC_AVAIL) begin
                     nxt_wr.we = 1'b1;
                     nxt_wr.ptr = wb_ptr;
                     nxt_wr.data = acc_ff;
                     nxt_rp_vld = 1'b0;
                     wb_release = 1'b1;
                     nxt_state = S_IDLE;
                  end
               end
               OP_ADDST_R, OP_INC_R, OP_DEC_R: begin
                  if (ACC_AVAIL || (op_ff != OP_ADDST_R)) begin
                     nxt_addend = OPREG_RDATA;
                     nxt_rp_vld = 1'b0;
                     if (op_ff == OP_INC_R) begin
                        nxt_acc = ACC_PLUS1;
                        nxt_carry = 1'b0;
                     end else if (op_ff == OP_DEC_R) begin
                        nxt_acc = ACC_ONES;
                        nxt_carry = 1'b0;
                     end
                     nxt_state = S_ADD;
                  end
               end
               OP_LD_M: begin
                  nxt_ma = OPREG_RDATA;
                  nxt_rp_vld = 1'b0;
                  nxt_mreq = 1'b1;
                  nxt_state = S_MREQ;
               end
               default: begin
                  nxt_state = S_IDLE;
               end
            endcase
         end
         S_ADD: begin
            // Adder runs this period; addend is held until the result is taken in S_RES
            nxt_state = S_RES;
         end
         S_RES: begin
            nxt_acc = add_sum;
            if ((op_ff == OP_INC_R) || (op_ff == OP_DEC_R)) begin
               nxt_carry = carry_ff | add_carry;
            end else begin
               nxt_carry = carry_ff ^ add_carry;
            end
            if (writes_reg(op_ff)) begin
               nxt_rp = wb_ptr;
               nxt_rp_vld = 1'b1;
               nxt_state = S_WB;
            end else begin
               nxt_state = S_IDLE;
            end
         end
         S_WB: begin
            nxt_wr.we = 1'b1;
            nxt_wr.ptr = rp_ff;
            nxt_wr.data = acc_ff;
            nxt_rp_vld = 1'b0;
            wb_release = 1'b1;
            nxt_state = S_STW;
         end
         S_STW: begin
            nxt_state = S_IDLE;
         end
         S_MREQ: begin
            // Request is re-sent every period until the memory accepts it
            if (MEM_ACCEPT) begin
               nxt_state = S_MDAT;
            end else begin
               nxt_mreq = 1'b1;
            end
         end
         S_MDAT: begin
            if (MEM_RVALID) begin
               nxt_acc = MEM_RDATA;
               nxt_carry = 1'b0;
               nxt_state = S_IDLE;
            end
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end

   // Register every piece of state; outputs come straight from these
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_ff <= S_IDLE;
         op_ff <= OP_NONE;
         acc_ff <= ACC_RST;
         carry_ff <= 1'b0;
         addend_ff <= ACC_RST;
         sub_ff <= 1'b0;
         rp_ff <= PTR_RST;
         rp_vld_ff <= 1'b0;
         wr_ff <= '0;
         ma_ff <= ACC_RST;
         mreq_ff <= 1'b0;
         take_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         acc_ff <= nxt_acc;
         carry_ff <= nxt_carry;
         addend_ff <= nxt_addend;
         sub_ff <= nxt_sub;
         rp_ff <= nxt_rp;
         rp_vld_ff <= nxt_rp_vld;
         wr_ff <= nxt_wr;
         ma_ff <= nxt_ma;
         mreq_ff <= nxt_mreq;
         take_ff <= nxt_take;
         ready_ff <= (nxt_state == S_IDLE);
      end
   end

   assign ISSUE_READY = ready_ff;
   assign PARCEL_TAKE = take_ff;
   assign OPERAND_READ_POINTER = rp_ff;
   assign OPERAND_READ_VALID = rp_vld_ff;
   assign WRITEBACK_POINTER = wb_ptr;
   assign OPREG_WR = wr_ff;
   assign MEMORY_ADDRESS_LATCH = ma_ff;
   assign MEM_REQ = mreq_ff;
   assign ACC = acc_ff;
   assign CARRY = carry_ff;

   // Small-designator subtract: adder period one edge after the issue edge, result period the edge after
   property p_sub_d_timing;
      @(posedge REF_CLK) disable iff (!RST_N)
      (issue_ok && ISSUE.op == OP_SUB_D) |=> (state_ff == S_ADD) ##1 (state_ff == S_RES);
   endproperty
   a_sub_d_timing: assert property (p_sub_d_timing) else $error("sub d timing wrong");

   property p_ldk_clear;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == S_CP1 && op_ff == OP_LD_K && PARCEL_VALID) |=>
      (acc_ff == $past(PARCEL_DATA) && !carry_ff && take_ff);
   endproperty
   a_ldk_clear: assert property (p_ldk_clear) else $error("load constant wrong");

   property p_parcel_stall;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == S_CP1 && op_ff inside {OP_LD_K, OP_AND_K, OP_ADD_K, OP_SUB_K} &&
       !PARCEL_VALID) |=> (state_ff == S_CP1 && !take_ff);
   endproperty
   a_parcel_stall: assert property (p_parcel_stall) else $error("parcel stall broken");

   property p_andk;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == S_CP1 && op_ff == OP_AND_K && PARCEL_VALID) |=>
      (acc_ff == ($past(acc_ff) & $past(PARCEL_DATA)) && !carry_ff);
   endproperty
   a_andk: assert property (p_andk) else $error("and constant wrong");

   property p_wb_block;
      @(posedge REF_CLK) disable iff (!RST_N)
      (wb_busy && ISSUE.valid && writes_reg(ISSUE.op)) |-> !issue_ok;
   endproperty
   a_wb_block: assert property (p_wb_block) else $error("issue despite held pointer");

   property p_st_hold;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == S_CP1 && op_ff == OP_ST_R && !ACC_AVAIL) |=>
      ($stable(rp_ff) && $stable(wb_ptr) && !wr_ff.we);
   endproperty
   a_st_hold: assert property (p_st_hold) else $error("store pointers moved");

   property p_rmw_wb;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == S_RES && writes_reg(op_ff)) |=> (rp_ff == wb_ptr) ##1
      (wr_ff.we && wr_ff.data == acc_ff);
   endproperty
   a_rmw_wb: assert property (p_rmw_wb) else $error("writeback wrong");

   property p_add_carry;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == S_RES && op_ff inside {OP_ADD_K, OP_ADD_R, OP_ADD_D}) |=>
      (acc_ff == $past(add_sum) && carry_ff == ($past(carry_ff) ^ $past(add_carry)));
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add result wrong");

   property p_mem_retry;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == S_MREQ && !MEM_ACCEPT) |=> (mreq_ff && state_ff == S_MREQ);
   endproperty
   a_mem_retry: assert property (p_mem_retry) else $error("request not re-sent");
endmodule
`default_nettype wire

/* File: hdl/iopa_pkg.sv */
// Package: constants, enums and carrier structs for the accumulator datapath
package iopa_pkg;
   localparam int DATA_W = 16;
   localparam int DESIG_W = 9;
   localparam int PTR_W = 9;
   localparam logic [15:0] ACC_RST = 16'h0000;
   localparam logic [15:0] ACC_ONES = 16'hFFFF;
   localparam logic [15:0] ACC_PLUS1 = 16'h0001;
   localparam logic [8:0] PTR_RST = 9'h000;
   // Period number at which a read-modify-write writes back
   localparam logic [2:0] RMW_WB_CP = 3'h4;
   // Operation codes accepted on the issue port
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_ADD_D = 5'h01, OP_SUB_D = 5'h02, OP_LD_K = 5'h03,
      OP_AND_K = 5'h04, OP_ADD_K = 5'h05, OP_SUB_K = 5'h06, OP_LD_R = 5'h07,
      OP_AND_R = 5'h08, OP_ADD_R = 5'h09, OP_SUB_R = 5'h0A, OP_ST_R = 5'h0B,
      OP_ADDST_R = 5'h0C, OP_INC_R = 5'h0D, OP_DEC_R = 5'h0E, OP_LD_M = 5'h0F
   } iopa_op_e;
   // Sequencer states, one-hot
   typedef enum logic [7:0] {
      S_IDLE = 8'h01, S_CP1 = 8'h02, S_ADD = 8'h04, S_RES = 8'h08,
      S_WB = 8'h10, S_MREQ = 8'h20, S_MDAT = 8'h40, S_STW = 8'h80
   } iopa_state_e;
   // Issue request from the instruction stack
   typedef struct packed {
      logic valid;
      iopa_op_e op;
      logic [DESIG_W-1:0] desig;
   } iopa_issue_s;
   // Write request toward the operand register file
   typedef struct packed {
      logic we;
      logic [PTR_W-1:0] ptr;
      logic [DATA_W-1:0] data;
   } iopa_opwr_s;
endpackage

/* File: hdl/iopa_wb_track.sv */
// Writeback pointer holder: busy while a store pointer is outstanding
`timescale 1ns/10ps
`default_nettype none
module iopa_wb_track
   import iopa_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [PTR_W-1:0] load_ptr,
   input wire logic release_ptr,
   output logic busy,
   output logic [PTR_W-1:0] ptr
);
   logic busy_ff;
   logic nxt_busy;
   logic [PTR_W-1:0] ptr_ff;
   logic [PTR_W-1:0] nxt_ptr;
   // Load wins over release so a back-to-back store keeps its pointer
   always_comb begin
      nxt_busy = busy_ff;
      nxt_ptr = ptr_ff;
      if (load) begin
         nxt_busy = 1'b1;
         nxt_ptr = load_ptr;
      end else if (release_ptr) begin
         nxt_busy = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
         ptr_ff <= PTR_RST;
      end else begin
         busy_ff <= nxt_busy;
         ptr_ff <= nxt_ptr;
      end
   end
   assign busy = busy_ff;
   assign ptr = ptr_ff;
endmodule
`default_nettype wire

/* File: testbench/iopa_datapath_bench.sv */
// Self-checking testbench for the accumulator datapath
`timescale 1ns/10ps
`default_nettype none
module iopa_datapath_bench
   import iopa_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   iopa_issue_s issue = '0;
   logic acc_avail = 1'b1;
   logic k_flush = 1'b0;
   logic [15:0] k_word = 16'h0000;
   logic [7:0] k_lag = 8'h00;
   logic [7:0] m_lag = 8'h00;
   logic [15:0] parcel_data, opreg_rdata, mem_rdata, mem_addr, acc, e_acc;
   logic parcel_valid, mem_accept, mem_rvalid, issue_ready, parcel_take;
   logic rd_valid, mem_req, carry, e_carry;
   logic [8:0] rd_ptr, wb_ptr;
   iopa_opwr_s opreg_wr;
   int n_mismatch = 0;
   int checks = 0;
   iopa_datapath u_iopa_datapath (
      .REF_CLK(clk), .RST_N(rst_n), .ISSUE(issue), .PARCEL_DATA(parcel_data),
      .PARCEL_VALID(parcel_valid), .OPREG_RDATA(opreg_rdata), .ACC_AVAIL(acc_avail),
      .MEM_ACCEPT(mem_accept), .MEM_RVALID(mem_rvalid), .MEM_RDATA(mem_rdata),
      .ISSUE_READY(issue_ready), .PARCEL_TAKE(parcel_take), .OPERAND_READ_POINTER(rd_ptr),
      .OPERAND_READ_VALID(rd_valid), .WRITEBACK_POINTER(wb_ptr), .OPREG_WR(opreg_wr),
      .MEMORY_ADDRESS_LATCH(mem_addr), .MEM_REQ(mem_req), .ACC(acc), .CARRY(carry));
   iopa_partner u_partner (
      .clk(clk), .rd_ptr(rd_ptr), .rd_valid(rd_valid), .wr(opreg_wr),
      .parcel_take(parcel_take), .k_flush(k_flush), .k_word(k_word), .k_lag(k_lag),
      .mem_req(mem_req), .mem_addr(mem_addr), .m_lag(m_lag), .rdata(opreg_rdata),
      .parcel_data(parcel_data), .parcel_valid(parcel_valid), .mem_accept(mem_accept),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   // 40 MHz clock
   always #12.5 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Bounded wait for the sequencer to report idle; a hang counts as a mismatch
   task automatic wait_ready;
      int i;
      i = 0;
      while (issue_ready !== 1'b1 && i < 50) begin
         @(negedge clk);
         i++;
      end
      if (i == 50) begin
         check(32'h0, 32'h1);
      end
   endtask
   // One issue pulse; the parcel delay restarts at the issue edge
   task automatic send(input iopa_op_e op, input logic [8:0] d);
      wait_ready();
      issue.valid = 1'b1;
      issue.op = op;
      issue.desig = d;
      k_flush = 1'b1;
      @(negedge clk);
      issue.valid = 1'b0;
      issue.op = OP_NONE;
      k_flush = 1'b0;
   endtask
   // Predict, issue, optionally time the accumulator update, then compare
   task automatic exec(input iopa_op_e op, input logic [8:0] d, input int lat,
                       input bit exact, input int stall);
      logic [15:0] b;
      logic [15:0] old;
      logic [16:0] s;
      old = e_acc;
      b = u_partner.regs[d];
      if (op inside {OP_ADD_D, OP_SUB_D}) begin
         b = {7'h00, d};
      end else if (op inside {OP_LD_K, OP_AND_K, OP_ADD_K, OP_SUB_K}) begin
         b = k_word;
      end else if (op == OP_LD_M) begin
         b = u_partner.regs[d] ^ 16'h5A5A;
      end
      s = {1'b0, e_acc} + {1'b0, b};
      if (op inside {OP_SUB_D, OP_SUB_K, OP_SUB_R}) begin
         s = {1'b0, e_acc} + {1'b0, ~b} + 17'h00001;
      end else if (op inside {OP_INC_R, OP_DEC_R}) begin
         s = {1'b0, (op == OP_INC_R) ? 16'h0001 : 16'hFFFF} + {1'b0, b};
      end
      // Loads and ANDs clear carry; increments and decrements take the carry-out; store keeps it; the rest toggle
      if (op inside {OP_LD_K, OP_LD_R, OP_LD_M}) begin
         e_acc = b;
         e_carry = 1'b0;
      end else if (op inside {OP_AND_K, OP_AND_R}) begin
         e_acc = e_acc & b;
         e_carry = 1'b0;
      end else if (op inside {OP_INC_R, OP_DEC_R}) begin
         e_acc = s[15:0];
         e_carry = s[16];
      end else if (op != OP_ST_R) begin
         e_acc = s[15:0];
         e_carry = e_carry ^ s[16];
      end
      if (stall > 0) begin
         acc_avail = 1'b0;
      end
      send(op, d);
      // Held instruction: no write, writeback pointer kept, read pointer too for a store
      for (int i = 0; i < stall; i++) begin
         check(opreg_wr.we, 1'b0);
         check(wb_ptr, d);
         if (op == OP_ST_R) begin
            check(rd_ptr, d);
         end
         @(negedge clk);
      end
      acc_avail = 1'b1;
      if (lat > 0) begin
         repeat (lat - 1) @(negedge clk);
         check(acc, old);
         @(negedge clk);
         if (exact) begin
            check(acc, e_acc);
         end
         if (exact && (op inside {OP_LD_K, OP_AND_K})) begin
            check(parcel_take, 1'b1);
         end
      end
      wait_ready();
      repeat (2) @(negedge clk);
      check(acc, e_acc);
      check(carry, e_carry);
      if (op inside {OP_ST_R, OP_ADDST_R, OP_INC_R, OP_DEC_R}) begin
         check(u_partner.regs[d], e_acc);
         check(rd_ptr, d);
      end
   endtask
   task automatic t_dsg;
      k_word = 16'h0005;
      exec(OP_LD_K, 9'h000, 0, 0, 0);
      exec(OP_SUB_D, 9'h1FF, 2, 1, 0);
      exec(OP_ADD_D, 9'h1FF, 2, 1, 0);
      $display("test designator done");
   endtask
   // Parcel late by three and two cycles stalls the transfer
   task automatic t_const;
      k_word = 16'h8001;
      exec(OP_LD_K, 9'h000, 1, 1, 0);
      k_word = 16'h0F0F;
      k_lag = 8'h03;
      exec(OP_AND_K, 9'h000, 4, 1, 0);
      k_word = 16'h8000;
      k_lag = 8'h00;
      exec(OP_ADD_K, 9'h000, 3, 1, 0);
      k_word = 16'h0001;
      k_lag = 8'h02;
      exec(OP_SUB_K, 9'h000, 5, 1, 0);
      k_lag = 8'h00;
      $display("test constant done");
   endtask
   task automatic t_reg;
      exec(OP_LD_R, 9'h010, 1, 1, 0);
      exec(OP_AND_R, 9'h1FF, 1, 1, 0);
      exec(OP_ADD_R, 9'h003, 3, 1, 0);
      exec(OP_SUB_R, 9'h100, 3, 1, 0);
      $display("test register done");
   endtask
   // Stores and read-modify-writes, with late accumulator data and carry edges
   task automatic t_rmw;
      exec(OP_ST_R, 9'h021, 0, 0, 3);
      exec(OP_ADDST_R, 9'h021, 3, 1, 2);
      k_word = 16'hFFFF;
      exec(OP_LD_K, 9'h000, 0, 0, 0);
      exec(OP_ST_R, 9'h030, 0, 0, 0);
      exec(OP_INC_R, 9'h030, 0, 0, 0);
      exec(OP_DEC_R, 9'h030, 0, 0, 0);
      exec(OP_DEC_R, 9'h021, 0, 0, 0);
      exec(OP_INC_R, 9'h022, 0, 0, 0);
      $display("test store done");
   endtask
   // Memory accepts only on the third request cycle
   task automatic t_mem;
      int n;
      m_lag = 8'h02;
      n = u_partner.n_req;
      exec(OP_LD_M, 9'h040, 0, 0, 0);
      check(32'(u_partner.n_req - n), 32'h3);
      $display("test memory done");
   endtask
   initial begin
      e_acc = 16'h0000;
      e_carry = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check(acc, 16'h0000);
      t_dsg();
      t_const();
      t_reg();
      t_rmw();
      t_mem();
      report_and_stop();
   end
   // 20 instructions of under 20 cycles each; 4000 cycles is ample
   initial begin
      #(25 * 4000);
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: testbench/iopa_partner.sv */
// Model of the instruction stack, operand register file and I/O memory
`timescale 1ns/10ps
`default_nettype none
module iopa_partner
   import iopa_pkg::*;
(
   input wire logic clk,
   input wire logic [PTR_W-1:0] rd_ptr,
   input wire logic rd_valid,
   input wire iopa_opwr_s wr,
   input wire logic parcel_take,
   input wire logic k_flush,
   input wire logic [DATA_W-1:0] k_word,
   input wire logic [7:0] k_lag,
   input wire logic mem_req,
   input wire logic [DATA_W-1:0] mem_addr,
   input wire logic [7:0] m_lag,
   output logic [DATA_W-1:0] rdata,
   output logic [DATA_W-1:0] parcel_data,
   output logic parcel_valid,
   output logic mem_accept,
   output logic mem_rvalid,
   output logic [DATA_W-1:0] mem_rdata
);
   logic [DATA_W-1:0] regs [0:511];
   logic [DATA_W-1:0] last_rd = 16'h0000;
   logic [DATA_W-1:0] held_adr = 16'h0000;
   logic [7:0] kcnt = 8'h00;
   logic [7:0] mcnt = 8'h00;
   logic [2:0] rv = 3'h0;
   int n_req = 0;
   // Distinct preset per register so a wrong pointer shows up
   initial begin
      for (int i = 0; i < 512; i++) begin
         regs[i] = 16'(i) ^ 16'hC3A0;
      end
   end
   // Idle read port shows the inverse of its previous output, so it alternates between the last word and its inverse
   assign rdata = rd_valid ? regs[rd_ptr] : ~last_rd;
   // Parcel arrives k_lag cycles after issue; absent data is inverted
   assign parcel_valid = (kcnt == 8'h00);
   assign parcel_data = parcel_valid ? k_word : ~k_word;
   assign mem_accept = mem_req && (mcnt == m_lag);
   assign mem_rvalid = rv[2];
   assign mem_rdata = rv[2] ? (held_adr ^ 16'h5A5A) : ~held_adr;
   // Register writes, parcel delay and memory acceptance with a slow answer
   always @(posedge clk) begin
      last_rd <= rdata;
      if (wr.we) begin
         regs[wr.ptr] <= wr.data;
      end
      if (k_flush || parcel_take) begin
         kcnt <= k_lag;
      end else if (kcnt != 8'h00) begin
         kcnt <= kcnt - 8'h01;
      end
      if (mem_req) begin
         n_req <= n_req + 1;
         mcnt <= mem_accept ? 8'h00 : mcnt + 8'h01;
      end
      if (mem_accept) begin
         held_adr <= mem_addr;
      end
      rv <= {rv[1:0], mem_accept};
   end
endmodule
`default_nettype wire
